//--- core/tasx_consts.vh
// constants for the table access / nibble exchange execution block
// assumes a core sequencer that presents one opcode per instruction cycle
// Operation
// [RULE_01] exchange nibbles, status flags untouched
// [RULE_02] d=0 to working reg, d=1 back
// [RULE_03] a=0 access bank, a=1 bank select
// [RULE_04] extended set, a=0, f<=5Fh: indexed offset
// [RULE_05] table read loads latch, flags untouched
// [RULE_06] read pointer update: none, post+, post-, pre+
// [RULE_07] pointer is 21-bit byte address
// [RULE_08] pointer bit 0 picks low/high byte
// [RULE_09] table write latch to holding reg [2:0]
// [RULE_10] write pointer updates same as read
// [RULE_11] table write two cycles, write in Q4
// [RULE_12] holding write never alters program memory
// [RULE_13] table writes allowed in user mode
// [RULE_14] table read two cycles, pointer wraps 21 bits
`ifndef TASX_CONSTS_VH
`define TASX_CONSTS_VH

`define TASX_PTR_W          21
`define TASX_HOLD_N         8
`define TASX_HOLD_SEL_W     3
`define TASX_SWAP_OPC       6'h0E
`define TASX_PROGRAM_BYTE_READ_OP_OPC      14'h0002
`define TASX_HOLDING_WRITE_OP_OPC      14'h0003
`define TASX_IDX_MAX        8'h5F
`define TASX_UPD_NONE       2'h0
`define TASX_UPD_POSTINC    2'h1
`define TASX_UPD_POSTDEC    2'h2
`define TASX_UPD_PREINC     2'h3
`define TASX_Q_LAST         2'h3
`define TASX_ACCESS_SPLIT   8'h60
`define TASX_ACCESS_HI_BANK 4'hF

`endif

//--- core/tasx_exec.v
// execution of the nibble exchange, table read and table write instructions
// assumes: instr_valid pulses in Q1 of an instruction cycle with the opcode,
// q_phase counts 0..3 continuously, program memory read data is combinational
`timescale 1ns/1ps
`include "tasx_consts.vh"

module tasx_exec (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // instruction from sequencer
   input  wire        instr_valid,
   input  wire [15:0] opcode,
   input  wire [1:0]  q_phase,
   // core state
   input  wire [3:0]  bank_select_reg,
   input  wire        ext_set_en,
   input  wire [11:0] index_base,
   input  wire [7:0]  file_rdata,
   // file register write
   output reg  [11:0] file_addr_r,
   output reg         file_indexed_r,
   output reg         file_we_r,
   output reg  [7:0]  file_wdata_r,
   output reg         wreg_we_r,
   output reg  [7:0]  wreg_wdata_r,
   // program memory
   output reg  [20:0] prog_addr_r,
   output reg         prog_byte_sel_r,
   output reg         prog_rd_r,
   input  wire [15:0] prog_rdata,
   // table state
   output reg  [20:0] program_byte_pointer_r,
   output reg  [7:0]  program_byte_latch_r,
   output reg  [63:0] holding_regs_r,
   output reg         busy_r,
   output reg         status_we_r
);

   ////////////////////////////////////////////////////////////////////
   // first cycle decodes, second cycle does the access
   localparam ST_IDLE   = 5'b00001;
   localparam ST_RD1    = 5'b00010;
   localparam ST_RD2    = 5'b00100;
   localparam ST_WT1    = 5'b01000;
   localparam ST_WT2    = 5'b10000;

   reg  [4:0]  state_r;
   reg  [4:0]  state_nxt;
   reg  [20:0] acc_addr_r;

   wire        is_swap;
   wire        is_rd;
   wire        is_wt;
   wire [20:0] upd_addr;
   wire [20:0] upd_next;
   wire [11:0] fa;
   wire        fa_idx;
   wire [7:0]  swapped;
   reg  [7:0]  rd_byte;

   assign is_swap = instr_valid && (opcode[15:10] == `TASX_SWAP_OPC);
   assign is_rd   = instr_valid && (opcode[15:2] == `TASX_PROGRAM_BYTE_READ_OP_OPC);
   assign is_wt   = instr_valid && (opcode[15:2] == `TASX_HOLDING_WRITE_OP_OPC);

   tasx_ptr_upd u_ptr (
      .ptr         (program_byte_pointer_r),
      .mode        (opcode[1:0]),
      .access_addr (upd_addr),
      .next_ptr    (upd_next)
   );

   tasx_file_addr u_fa (
      .f_operand       (opcode[7:0]),
      .a_bit           (opcode[8]),
      .bank_select_reg (bank_select_reg),
      .ext_set_en      (ext_set_en),
      .index_base      (index_base),
      .file_addr       (fa),
      .indexed         (fa_idx)
   );

   // [RULE_01] exchange nibbles
   assign swapped = {file_rdata[3:0], file_rdata[7:4]};

   // [RULE_08] byte of word by pointer bit 0
   always @* begin
      if (acc_addr_r[0]) begin
         rd_byte = prog_rdata[15:8];
      end else begin
         rd_byte = prog_rdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (is_rd) begin
               state_nxt = ST_RD1;
            end else if (is_wt) begin
               state_nxt = ST_WT1;
            end
         end
         // [RULE_11] [RULE_14] wait out decode cycle
         ST_RD1: begin
            if (q_phase == `TASX_Q_LAST) begin
               state_nxt = ST_RD2;
            end
         end
         ST_WT1: begin
            if (q_phase == `TASX_Q_LAST) begin
               state_nxt = ST_WT2;
            end
         end
         ST_RD2: begin
            if (q_phase == `TASX_Q_LAST) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WT2: begin
            if (q_phase == `TASX_Q_LAST) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r                <= ST_IDLE;
         acc_addr_r             <= 21'h000000;
         file_addr_r            <= 12'h000;
         file_indexed_r         <= 1'b0;
         file_we_r              <= 1'b0;
         file_wdata_r           <= 8'h00;
         wreg_we_r              <= 1'b0;
         wreg_wdata_r           <= 8'h00;
         prog_addr_r            <= 21'h000000;
         prog_byte_sel_r        <= 1'b0;
         prog_rd_r              <= 1'b0;
         program_byte_pointer_r <= 21'h000000;
         program_byte_latch_r   <= 8'h00;
         holding_regs_r         <= 64'h0000000000000000;
         busy_r                 <= 1'b0;
         status_we_r            <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         file_we_r   <= 1'b0;
         wreg_we_r   <= 1'b0;
         prog_rd_r   <= 1'b0;
         // [RULE_01] [RULE_05] [RULE_09] flags never written here
         status_we_r <= 1'b0;
         busy_r      <= (state_nxt != ST_IDLE);
         if (is_swap) begin
            file_addr_r    <= fa;
            file_indexed_r <= fa_idx;
            // [RULE_02] destination select
            if (opcode[9]) begin
               file_we_r    <= 1'b1;
               file_wdata_r <= swapped;
            end else begin
               wreg_we_r    <= 1'b1;
               wreg_wdata_r <= swapped;
            end
         end
         if (state_r == ST_IDLE && (is_rd || is_wt)) begin
            // [RULE_07] [RULE_14] 21-bit pointer update
            acc_addr_r             <= upd_addr;
            program_byte_pointer_r <= upd_next;
            prog_addr_r            <= upd_addr;
            prog_byte_sel_r        <= upd_addr[0];
         end
         if (state_r == ST_RD2) begin
            prog_rd_r <= 1'b1;
            // [RULE_05] [RULE_14] latch loads in Q4
            if (q_phase == `TASX_Q_LAST) begin
               program_byte_latch_r <= rd_byte;
            end
         end
         // [RULE_11] [RULE_12] [RULE_13] holding write in Q4 only
         if (state_r == ST_WT2 && q_phase == `TASX_Q_LAST) begin
            holding_regs_r[acc_addr_r[2:0]*8 +: 8] <= program_byte_latch_r;
         end
      end
   end

endmodule

//--- core/tasx_file_addr.v
// file register address formation for byte-oriented instructions
// assumes the index register value is supplied by the core
`timescale 1ns/1ps
`include "tasx_consts.vh"

module tasx_file_addr (
   // operand fields
   input  wire [7:0]  f_operand,
   input  wire        a_bit,
   // core state
   input  wire [3:0]  bank_select_reg,
   input  wire        ext_set_en,
   input  wire [11:0] index_base,
   // result
   output reg  [11:0] file_addr,
   output reg         indexed
);

   always @* begin
      indexed   = 1'b0;
      file_addr = 12'h000;
      if (a_bit) begin
         // [RULE_03] bank select supplies bank
         file_addr = {bank_select_reg, f_operand};
      end else if (ext_set_en && (f_operand <= `TASX_IDX_MAX)) begin
         // [RULE_04] indexed literal offset
         indexed   = 1'b1;
         file_addr = index_base + {4'h0, f_operand};
      end else if (f_operand < `TASX_ACCESS_SPLIT) begin
         // [RULE_03] access bank low half
         file_addr = {4'h0, f_operand};
      end else begin
         file_addr = {`TASX_ACCESS_HI_BANK, f_operand};
      end
   end

endmodule

//--- core/tasx_ptr_upd.v
// pointer arithmetic for the table access instructions
// assumes a combinational caller that registers the result
`timescale 1ns/1ps
`include "tasx_consts.vh"

module tasx_ptr_upd (
   // pointer and mode
   input  wire [`TASX_PTR_W-1:0] ptr,
   input  wire [1:0]             mode,
   // results
   output reg  [`TASX_PTR_W-1:0] access_addr,
   output reg  [`TASX_PTR_W-1:0] next_ptr
);

   wire [`TASX_PTR_W-1:0] ptr_inc;
   wire [`TASX_PTR_W-1:0] ptr_dec;

   // [RULE_14] wrap within 21 bits
   assign ptr_inc = ptr + {{(`TASX_PTR_W-1){1'b0}}, 1'b1};
   assign ptr_dec = ptr - {{(`TASX_PTR_W-1){1'b0}}, 1'b1};

   // [RULE_06] [RULE_10] four update modes
   always @* begin
      access_addr = ptr;
      next_ptr    = ptr;
      case (mode)
         `TASX_UPD_NONE: begin
            next_ptr = ptr;
         end
         `TASX_UPD_POSTINC: begin
            next_ptr = ptr_inc;
         end
         `TASX_UPD_POSTDEC: begin
            next_ptr = ptr_dec;
         end
         `TASX_UPD_PREINC: begin
            access_addr = ptr_inc;
            next_ptr    = ptr_inc;
         end
         default: begin
            next_ptr = ptr;
         end
      endcase
   end

endmodule

//--- verif/tasx_exec_props.sv
// checker for tasx_exec, bound onto it
// assumes q_phase runs 0..3 freely
`timescale 1ns/1ps
`include "tasx_consts.vh"
module tasx_exec_props (
   input wire        ref_clk, rst, instr_valid, ext_set_en, file_indexed_r, file_we_r, wreg_we_r,
   input wire        prog_byte_sel_r, prog_rd_r, busy_r, status_we_r,
   input wire [1:0]  q_phase,
   input wire [3:0]  bank_select_reg,
   input wire [7:0]  file_rdata, file_wdata_r, wreg_wdata_r, program_byte_latch_r,
   input wire [11:0] index_base, file_addr_r,
   input wire [15:0] opcode, prog_rdata,
   input wire [20:0] prog_addr_r, program_byte_pointer_r,
   input wire [63:0] holding_regs_r
);
   reg  [15:0] op_q, pd_q;
   reg  [7:0]  fr_q;
   reg  [20:0] pp_q;
   wire        swp = instr_valid && opcode[15:10] == `TASX_SWAP_OPC && !busy_r;
   wire        tbl = instr_valid && !busy_r && opcode[15:3] == 13'h0001;
   wire [7:0]  sw  = {fr_q[3:0], fr_q[7:4]};
   wire [20:0] nx  = (op_q[1:0] == 2'h2) ? pp_q - 21'h1 : pp_q + {20'h0, op_q[0]};
   wire [20:0] ac  = pp_q + {20'h0, op_q[1:0] == 2'h3};
   always @(posedge ref_clk) begin
      op_q <= opcode;
      pd_q <= prog_rdata;
      fr_q <= file_rdata;
      pp_q <= program_byte_pointer_r;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   no_flag_write_a: assert property (!status_we_r) else $error("flag write");
   swap_dest_a: assert property (swp |=> (op_q[9] ? file_we_r && file_wdata_r == sw
      : wreg_we_r && wreg_wdata_r == sw)) else $error("swap result");
   bank_sel_a: assert property (swp && opcode[8] |=> file_addr_r == {$past(bank_select_reg), op_q[7:0]})
      else $error("bank address");
   indexed_addr_a: assert property (swp && !opcode[8] && ext_set_en && opcode[7:0] <= `TASX_IDX_MAX
      |=> file_indexed_r && file_addr_r == $past(index_base) + {4'h0, op_q[7:0]}) else $error("indexed address");
   ptr_update_a: assert property (tbl |=> program_byte_pointer_r == nx) else $error("pointer");
   read_addr_a: assert property (tbl && !opcode[2] |=> prog_addr_r == ac && prog_byte_sel_r == ac[0])
      else $error("read address");
   latch_load_a: assert property (!$stable(program_byte_latch_r) |-> $past(prog_rd_r) &&
      $past(q_phase) == `TASX_Q_LAST && program_byte_latch_r == ($past(prog_byte_sel_r) ? pd_q[15:8] : pd_q[7:0]))
      else $error("latch load");
   hold_write_a: assert property (!$stable(holding_regs_r) |-> $past(busy_r) && !$past(prog_rd_r)
      && $past(q_phase) == `TASX_Q_LAST) else $error("holding write");
   cover property (swp && opcode[9]);
   cover property (tbl && opcode[2] && opcode[1:0] == 2'h3);
   cover property (!$stable(program_byte_latch_r));
endmodule
bind tasx_exec tasx_exec_props u_tasx_exec_props (.*);

//--- verif/tasx_pmem_model.sv
// program memory model for the table access block
// assumes a combinational word read addressed by byte address
`timescale 1ns/1ps
module tasx_pmem_model (
   // read request
   input  wire [20:0] prog_addr,
   input  wire        prog_rd,
   // read data
   output wire [15:0] prog_rdata
);
   ////////////////////////////////////////
   // byte address, both bytes in a word
   wire [15:0] word = {prog_addr[8:1] ^ 8'hC3, prog_addr[8:1] + 8'h05};
   // idle bus shows the inverse so stale data never matches
   assign prog_rdata = prog_rd ? word : ~word;
endmodule

//--- verif/test_table_access_swap_exec.sv
// self-checking bench for tasx_exec with a program memory model
// assumes opcodes are offered in Q1 and q_phase counts freely
`timescale 1ns/1ps
`include "tasx_consts.vh"
module test_table_access_swap_exec;
   reg         ref_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
   reg  [15:0] opcode = 16'h0000;
   reg  [1:0]  q_phase = 2'h0;
   reg  [3:0]  bank_select_reg = 4'h5;
   reg  [11:0] index_base = 12'h123;
   reg  [7:0]  file_rdata = 8'h00, el = 8'h00;
   reg  [20:0] ep = 21'h0, acc;
   reg  [63:0] eh = 64'h0;
   wire [11:0] file_addr_r;
   wire [7:0]  file_wdata_r, wreg_wdata_r, program_byte_latch_r;
   wire [20:0] prog_addr_r, program_byte_pointer_r;
   wire [15:0] prog_rdata;
   wire [63:0] holding_regs_r;
   wire        file_indexed_r, file_we_r, wreg_we_r, prog_byte_sel_r, prog_rd_r, busy_r, status_we_r;
   integer     num_errors = 0, comparisons = 0, i;
   tasx_exec u_tasx_exec (.*);
   tasx_pmem_model u_tasx_pmem_model (.prog_addr(prog_addr_r), .prog_rd(prog_rd_r), .prog_rdata(prog_rdata));
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk or posedge rst) q_phase <= rst ? 2'h0 : q_phase + 2'h1;
   ////////////////////////////////////////
   task cmp(input [63:0] got, input [63:0] exp); begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end endtask
   task issue(input [15:0] op); begin
      @(posedge ref_clk) #1;
      while (q_phase !== 2'h0) @(posedge ref_clk) #1;
      instr_valid = 1'b1;
      opcode = op;
      @(posedge ref_clk) #1 instr_valid = 1'b0;
   end endtask
   task t_swap(input d, input a, input ex, input [7:0] f, input [7:0] rd, input [11:0] ea, input ei); begin
      ext_set_en = ex;
      file_rdata = rd;
      issue({`TASX_SWAP_OPC, d, a, f});
      for (i = 0; i < 3 && !(file_we_r || wreg_we_r); i = i + 1) @(posedge ref_clk) #1;
      cmp({file_we_r, wreg_we_r}, d ? 2'h2 : 2'h1);
      cmp(d ? file_wdata_r : wreg_wdata_r, {rd[3:0], rd[7:4]});
      cmp({file_indexed_r, file_addr_r, status_we_r}, {ei, ea, 1'b0});
      $display("swap test done");
   end endtask
   task t_tbl(input wt, input [1:0] m); begin
      acc = ep + {20'h0, m == 2'h3};
      ep = (m == 2'h2) ? ep - 21'h1 : ep + {20'h0, m[0]};
      issue({wt ? `TASX_HOLDING_WRITE_OP_OPC : `TASX_PROGRAM_BYTE_READ_OP_OPC, m});
      repeat (7) @(posedge ref_clk);
      #1;
      if (wt) eh[acc[2:0]*8 +: 8] = el;
      else el = acc[0] ? acc[8:1] ^ 8'hC3 : acc[8:1] + 8'h05;
      cmp({busy_r, program_byte_pointer_r, program_byte_latch_r}, {1'b0, ep, el});
      cmp(holding_regs_r, eh);
      cmp({status_we_r, prog_addr_r, prog_byte_sel_r}, {1'b0, acc, acc[0]});
      $display("table test done");
   end endtask
   task give_verdict; begin
      $display("num_errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end endtask
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      #1 rst = 1'b0;
      t_swap(0, 0, 0, 8'h12, 8'h53, 12'h012, 0);
      t_swap(1, 1, 0, 8'h80, 8'hA7, 12'h580, 0);
      t_swap(1, 0, 0, 8'h70, 8'h3C, 12'hF70, 0);
      t_swap(0, 0, 1, 8'h5F, 8'hE1, 12'h182, 1);
      t_swap(1, 0, 1, 8'h60, 8'h0F, 12'hF60, 0);
      $display("swap tests done");
      t_tbl(0, 2'h2);
      t_tbl(0, 2'h3);
      t_tbl(0, 2'h1);
      t_tbl(0, 2'h0);
      t_tbl(1, 2'h1);
      t_tbl(0, 2'h3);
      t_tbl(1, 2'h3);
      t_tbl(1, 2'h2);
      t_tbl(1, 2'h0);
      $display("table tests done");
      give_verdict;
   end
   initial begin
      #20000;
      num_errors = num_errors + 1;
      give_verdict;
   end
endmodule
